/* File: hw/sdp_pin_ctrl.sv */
// SDRAM pin-level controller with strap capture and read FIFO
`timescale 1ns/10ps
`default_nettype none
module sdp_pin_ctrl (
   // Clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Access requests
   input wire logic req_valid_in,
   output logic req_ready_out,
   input wire logic req_write_in,
   input wire logic [sdp_pkg::ROW_IDX_W-1:0] req_row_in,
   input wire logic [sdp_pkg::BANK_W-1:0] req_bank_in,
   input wire logic [sdp_pkg::ADDR_W-1:0] req_row_addr_in,
   input wire logic [sdp_pkg::ADDR_W-1:0] req_col_addr_in,
   input wire logic [sdp_pkg::DATA_W-1:0] req_wdata_in,
   input wire logic [sdp_pkg::MASK_W-1:0] req_byte_en_in,
   // Refresh and suspend
   input wire logic refresh_req_in,
   output logic refresh_ack_out,
   input wire logic suspend_in,
   output logic suspended_out,
   // Read data
   output logic rd_valid_out,
   input wire logic rd_ready_in,
   output logic [sdp_pkg::DATA_W-1:0] rd_data_out,
   // Processor reset and strap
   input wire logic cpu_reset_n_in,
   input wire logic strap_in,
   output logic cpu_address_bus_15_out,
   output logic cpu_address_bus_15_oe_out,
   // SDRAM pins
   output logic [sdp_pkg::ADDR_W-1:0] mem_addr_primary_out,
   output logic [sdp_pkg::INV_HI-sdp_pkg::INV_LO:0] mem_addr_inv_copy_b_out,
   output logic [sdp_pkg::INV_HI-sdp_pkg::INV_LO:0] mem_addr_inv_copy_c_out,
   output logic [sdp_pkg::BANK_W-1:0] mem_bank_select_out,
   input wire logic [sdp_pkg::DATA_W-1:0] mem_data_bus_in,
   output logic [sdp_pkg::DATA_W-1:0] mem_data_bus_out,
   output logic mem_data_bus_oe_out,
   output logic [sdp_pkg::MASK_W-1:0] mem_data_mask_out,
   output logic [sdp_pkg::ROWS-1:0] mem_row_select_a_n_out,
   output logic [sdp_pkg::ROWS-1:0] mem_row_select_b_n_out,
   output logic mem_row_strobe_n_out,
   output logic mem_col_strobe_n_out,
   output logic mem_write_enable_n_out,
   output logic [sdp_pkg::ROWS-1:0] mem_row_clock_enable_out
);
   sdp_pkg::sdp_state_t state, next_state;
   logic [sdp_pkg::CNT_W-1:0] cnt, next_cnt;
   logic [2:0] cmd, next_cmd;
   logic [sdp_pkg::ADDR_W-1:0] addr, next_addr;
   logic [sdp_pkg::BANK_W-1:0] bank, next_bank;
   logic [sdp_pkg::ROWS-1:0] next_sel, cs_n, cke, next_cke;
   logic [sdp_pkg::MASK_W-1:0] dqm, next_dqm;
   logic doe, next_doe;
   logic [sdp_pkg::DATA_W-1:0] dout, next_dout;
   logic ref_ack, next_ref_ack;
   // Latched request
   logic op_write;
   logic [sdp_pkg::ROWS-1:0] op_row;
   logic [sdp_pkg::ADDR_W-1:0] op_row_addr;
   logic [sdp_pkg::ADDR_W-1:0] op_col_addr;
   logic [sdp_pkg::DATA_W-1:0] op_wdata;
   logic [sdp_pkg::MASK_W-1:0] op_byte_en;
   // Synchronisers
   logic [sdp_pkg::DATA_W-1:0] data_sync1, data_sync2;
   logic cpu_rst_sync1, cpu_rst_sync2;
   logic strap_sync1, strap_sync2, strap_val;
   logic [sdp_pkg::CNT_W-1:0] hold_cnt;
   logic a15_oe;
   // Read data stream into the FIFO
   sdp_stream_if #(.WIDTH(sdp_pkg::DATA_W)) push_bus ();
   sdp_stream_if #(.WIDTH(sdp_pkg::DATA_W)) pop_bus ();
   sdp_fifo #(
      .WIDTH(sdp_pkg::DATA_W),
      .DEPTH(sdp_pkg::FIFO_DEPTH)
   ) u_rd_fifo (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .push_if(push_bus),
      .pop_if(pop_bus)
   );
   assign push_bus.valid = (state == sdp_pkg::ST_RDCAP) && (cnt == '0);
   assign push_bus.data = data_sync2;
   assign rd_valid_out = pop_bus.valid;
   assign rd_data_out = pop_bus.data;
   assign pop_bus.ready = rd_ready_in;
   // Decodes
   wire idle_free = (state == sdp_pkg::ST_IDLE) && (cnt == '0);
   wire room_ok = req_write_in || push_bus.ready;
   wire [sdp_pkg::ROWS-1:0] req_row_hot = sdp_pkg::ROWS'(1) << req_row_in;
   wire bank_change = (next_bank != bank);
   wire cmd_idle = (next_cmd == sdp_pkg::CMD_NOP);
   wire [sdp_pkg::ROWS-1:0] next_cs_n = (bank_change || cmd_idle) ? sdp_pkg::ROWS_ALL : ~next_sel;
   wire cnt_zero = (cnt == '0);
   wire [sdp_pkg::CNT_W-1:0] cnt_dec = cnt_zero ? cnt : cnt - sdp_pkg::CNT_W'(1);
   assign req_ready_out = idle_free && !suspend_in && !refresh_req_in && room_ok;
   assign refresh_ack_out = ref_ack;
   assign suspended_out = (state == sdp_pkg::ST_SELF);
   // Pin outputs
   assign mem_addr_primary_out = addr;
   assign mem_addr_inv_copy_b_out = ~addr[sdp_pkg::INV_HI:sdp_pkg::INV_LO];
   assign mem_addr_inv_copy_c_out = ~addr[sdp_pkg::INV_HI:sdp_pkg::INV_LO];
   assign mem_bank_select_out = bank;
   assign mem_row_select_a_n_out = cs_n;
   assign mem_row_select_b_n_out = cs_n;
   assign mem_row_strobe_n_out = cmd[2];
   assign mem_col_strobe_n_out = cmd[1];
   assign mem_write_enable_n_out = cmd[0];
   assign mem_row_clock_enable_out = cke;
   assign mem_data_mask_out = dqm;
   assign mem_data_bus_oe_out = doe;
   assign mem_data_bus_out = dout;
   assign cpu_address_bus_15_out = strap_val;
   assign cpu_address_bus_15_oe_out = a15_oe;
   // Next-state logic
   always_comb begin
      next_state = state;
      next_cnt = cnt_dec;
      next_cmd = sdp_pkg::CMD_NOP;
      next_addr = addr;
      next_bank = bank;
      next_sel = sdp_pkg::ROWS_NONE;
      next_cke = cke;
      next_dqm = sdp_pkg::MASK_OFF;
      next_doe = 1'b0;
      next_dout = dout;
      next_ref_ack = 1'b0;
      case (state)
         sdp_pkg::ST_INIT_PRE: begin
            next_cmd = sdp_pkg::CMD_PRE;
            next_addr[sdp_pkg::AUTO_PRE_BIT] = 1'b1;
            next_sel = sdp_pkg::ROWS_ALL;
            next_cnt = sdp_pkg::RP_CYC;
            next_state = sdp_pkg::ST_INIT_WAIT;
         end
         sdp_pkg::ST_INIT_WAIT: begin
            if (cnt_zero) begin
               next_state = sdp_pkg::ST_INIT_REF;
            end
         end
         sdp_pkg::ST_INIT_REF: begin
            next_cmd = sdp_pkg::CMD_REF;
            next_sel = sdp_pkg::ROWS_ALL;
            next_cnt = sdp_pkg::RFC_CYC;
            next_state = sdp_pkg::ST_INIT_WAIT2;
         end
         sdp_pkg::ST_INIT_WAIT2: begin
            if (cnt_zero) begin
               next_state = sdp_pkg::ST_INIT_MRS;
            end
         end
         sdp_pkg::ST_INIT_MRS: begin
            next_cmd = sdp_pkg::CMD_MRS;
            next_addr = sdp_pkg::MODE_WORD;
            next_sel = sdp_pkg::ROWS_ALL;
            next_cnt = sdp_pkg::MRD_CYC;
            next_state = sdp_pkg::ST_IDLE;
         end
         sdp_pkg::ST_IDLE: begin
            if (cnt_zero) begin
               next_cke = sdp_pkg::ROWS_NONE;
               if (suspend_in) begin
                  next_cke = sdp_pkg::ROWS_ALL;
                  next_state = sdp_pkg::ST_SR_ENTER;
               end else if (refresh_req_in) begin
                  next_cke = sdp_pkg::ROWS_ALL;
                  next_state = sdp_pkg::ST_REF;
               end else if (req_valid_in && room_ok) begin
                  next_bank = req_bank_in;
                  next_cke = req_row_hot;
                  next_cnt = sdp_pkg::BANK_SETUP_CYC - sdp_pkg::CNT_W'(1);
                  next_state = sdp_pkg::ST_SETUP;
               end
            end
         end
         sdp_pkg::ST_SETUP: begin
            if (cnt_zero) begin
               next_cmd = sdp_pkg::CMD_ACT;
               next_addr = op_row_addr;
               next_sel = op_row;
               next_cnt = sdp_pkg::RCD_CYC - sdp_pkg::CNT_W'(1);
               next_state = sdp_pkg::ST_RCD;
            end
         end
         sdp_pkg::ST_RCD: begin
            if (cnt_zero) begin
               next_addr = op_col_addr;
               next_addr[sdp_pkg::AUTO_PRE_BIT] = 1'b1;
               next_sel = op_row;
               if (op_write) begin
                  next_cmd = sdp_pkg::CMD_WR;
                  next_doe = 1'b1;
                  next_dout = op_wdata;
                  next_dqm = ~op_byte_en;
                  next_cnt = sdp_pkg::WR_CYC + sdp_pkg::RP_CYC;
                  next_state = sdp_pkg::ST_WAIT;
               end else begin
                  next_cmd = sdp_pkg::CMD_RD;
                  next_dqm = ~sdp_pkg::MASK_OFF;
                  next_cnt = sdp_pkg::RD_CAP_CYC;
                  next_state = sdp_pkg::ST_RDCAP;
               end
            end
         end
         sdp_pkg::ST_RDCAP: begin
            next_dqm = ~sdp_pkg::MASK_OFF;
            if (cnt_zero) begin
               next_cnt = sdp_pkg::RP_CYC;
               next_state = sdp_pkg::ST_WAIT;
            end
         end
         sdp_pkg::ST_REF: begin
            next_cmd = sdp_pkg::CMD_REF;
            next_sel = sdp_pkg::ROWS_ALL;
            next_ref_ack = 1'b1;
            next_cnt = sdp_pkg::RFC_CYC;
            next_state = sdp_pkg::ST_WAIT;
         end
         sdp_pkg::ST_WAIT: begin
            if (cnt_zero) begin
               next_state = sdp_pkg::ST_IDLE;
            end
         end
         sdp_pkg::ST_SR_ENTER: begin
            next_cmd = sdp_pkg::CMD_REF;
            next_sel = sdp_pkg::ROWS_ALL;
            next_cke = sdp_pkg::ROWS_NONE;
            next_state = sdp_pkg::ST_SELF;
         end
         sdp_pkg::ST_SELF: begin
            if (!suspend_in) begin
               next_cke = sdp_pkg::ROWS_ALL;
               next_cnt = sdp_pkg::XSR_CYC;
               next_state = sdp_pkg::ST_WAIT;
            end
         end
         default: begin
            next_state = sdp_pkg::ST_INIT_PRE;
         end
      endcase
   end
   // Controller and pin registers
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state <= sdp_pkg::ST_INIT_PRE;
         cnt <= '0;
         cmd <= sdp_pkg::CMD_NOP;
         addr <= '0;
         bank <= '0;
         cs_n <= sdp_pkg::ROWS_ALL;
         cke <= sdp_pkg::ROWS_ALL;
         dqm <= sdp_pkg::MASK_OFF;
         doe <= 1'b0;
         dout <= '0;
         ref_ack <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         cmd <= next_cmd;
         addr <= next_addr;
         bank <= next_bank;
         cs_n <= next_cs_n;
         cke <= next_cke;
         dqm <= next_dqm;
         doe <= next_doe;
         dout <= next_dout;
         ref_ack <= next_ref_ack;
      end
   end
   // Request capture
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         op_write <= 1'b0;
         op_row <= sdp_pkg::ROWS_NONE;
         op_row_addr <= '0;
         op_col_addr <= '0;
         op_wdata <= '0;
         op_byte_en <= '0;
      end else if (req_valid_in && req_ready_out) begin
         op_write <= req_write_in;
         op_row <= req_row_hot;
         op_row_addr <= req_row_addr_in;
         op_col_addr <= req_col_addr_in;
         op_wdata <= req_wdata_in;
         op_byte_en <= req_byte_en_in;
      end
   end
   // Pin synchronisers
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         data_sync1 <= '0;
         data_sync2 <= '0;
         cpu_rst_sync1 <= 1'b0;
         cpu_rst_sync2 <= 1'b0;
         strap_sync1 <= 1'b1;
         strap_sync2 <= 1'b1;
      end else begin
         data_sync1 <= mem_data_bus_in;
         data_sync2 <= data_sync1;
         cpu_rst_sync1 <= cpu_reset_n_in;
         cpu_rst_sync2 <= cpu_rst_sync1;
         strap_sync1 <= strap_in;
         strap_sync2 <= strap_sync1;
      end
   end
   // Strap capture and processor address bit 15 drive
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         strap_val <= 1'b1;
         hold_cnt <= sdp_pkg::STRAP_HOLD_CYC;
         a15_oe <= 1'b1;
      end else if (!cpu_rst_sync2) begin
         strap_val <= strap_sync2;
         hold_cnt <= sdp_pkg::STRAP_HOLD_CYC;
         a15_oe <= 1'b1;
      end else begin
         hold_cnt <= (hold_cnt == '0) ? hold_cnt : hold_cnt - sdp_pkg::CNT_W'(1);
         a15_oe <= (hold_cnt != '0);
      end
   end
endmodule // sdp_pin_ctrl
`default_nettype wire

/* File: hw/sdp_pkg.sv */
// Constants and types for the SDRAM pin interface
`default_nettype none
package sdp_pkg;
   // Widths
   localparam int ADDR_W = 13;
   localparam int BANK_W = 2;
   localparam int DATA_W = 64;
   localparam int MASK_W = 8;
   localparam int ROWS = 6;
   localparam int ROW_IDX_W = 3;
   localparam int CNT_W = 4;
   localparam int FIFO_DEPTH = 8;
   // Pin field positions
   localparam int INV_LO = 4;
   localparam int INV_HI = 7;
   localparam int STRAP_BIT = 5;
   localparam int AUTO_PRE_BIT = 10;
   // Timing in ns and derived cycle counts
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_RCD_NS = 20;
   localparam int T_RP_NS = 20;
   localparam int T_WR_NS = 15;
   localparam int T_RFC_NS = 70;
   localparam int T_XSR_NS = 75;
   localparam int T_MRD_NS = 30;
   localparam logic [CNT_W-1:0] RCD_CYC = CNT_W'((T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RP_CYC = CNT_W'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WR_CYC = CNT_W'((T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] RFC_CYC = CNT_W'((T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] XSR_CYC = CNT_W'((T_XSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] MRD_CYC = CNT_W'((T_MRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] BANK_SETUP_CYC = 4'h2;
   localparam logic [CNT_W-1:0] CAS_LAT = 4'h2;
   localparam logic [CNT_W-1:0] SYNC_STAGES = 4'h2;
   localparam logic [CNT_W-1:0] RD_CAP_CYC = CAS_LAT + SYNC_STAGES;
   localparam logic [CNT_W-1:0] STRAP_HOLD_CYC = 4'h2;
   // Command encodings {row strobe, column strobe, write enable}, active low
   localparam logic [2:0] CMD_NOP = 3'h7;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_RD = 3'h5;
   localparam logic [2:0] CMD_WR = 3'h4;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_MRS = 3'h0;
   // Mode word: burst of one, latency two
   localparam logic [ADDR_W-1:0] MODE_WORD = 13'h0020;
   localparam logic [MASK_W-1:0] MASK_OFF = 8'hff;
   localparam logic [ROWS-1:0] ROWS_ALL = 6'h3f;
   localparam logic [ROWS-1:0] ROWS_NONE = 6'h00;
   // Controller states
   typedef enum logic [3:0] {
      ST_INIT_PRE, ST_INIT_REF, ST_INIT_MRS, ST_IDLE, ST_SETUP, ST_RCD,
      ST_RDCAP, ST_WAIT, ST_REF, ST_SR_ENTER, ST_SELF, ST_INIT_WAIT, ST_INIT_WAIT2
   } sdp_state_t;
endpackage
`default_nettype wire

/* File: hw/sdp_stream_if.sv */
// Valid/ready word stream between the controller and its FIFO
`timescale 1ns/10ps
`default_nettype none
interface sdp_stream_if #(parameter int WIDTH = 64);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface // sdp_stream_if
`default_nettype wire

/* File: hw/sdp_fifo.sv */
// Read-data FIFO with parameter width and depth
`timescale 1ns/10ps
`default_nettype none
module sdp_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Streams
   sdp_stream_if.sink push_if,
   sdp_stream_if.source pop_if
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [CW-1:0] count;
   wire do_push = push_if.valid && push_if.ready;
   wire do_pop = pop_if.valid && pop_if.ready;
   assign push_if.ready = (count != CW'(DEPTH));
   assign pop_if.valid = (count != '0);
   assign pop_if.data = mem[rd_ptr];
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (do_push) begin
            wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
         end
         if (do_pop) begin
            rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
         end
         count <= count + CW'(do_push) - CW'(do_pop);
      end
   end
   always_ff @(posedge clk_in) begin
      if (do_push) begin
         mem[wr_ptr] <= push_if.data;
      end
   end
endmodule // sdp_fifo
`default_nettype wire

/* File: dv/sdp_pin_ctrl_properties.sv */
// Concurrent checks on the SDRAM pin controller ports
`timescale 1ns/10ps
`default_nettype none
module sdp_pin_ctrl_properties (
   // Clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Requests and strap
   input wire logic req_valid_in,
   input wire logic req_ready_out,
   input wire logic req_write_in,
   input wire logic [2:0] req_row_in,
   input wire logic [1:0] req_bank_in,
   input wire logic [12:0] req_row_addr_in,
   input wire logic [12:0] req_col_addr_in,
   input wire logic [63:0] req_wdata_in,
   input wire logic [7:0] req_byte_en_in,
   input wire logic cpu_reset_n_in,
   input wire logic strap_in,
   input wire logic cpu_address_bus_15_out,
   input wire logic cpu_address_bus_15_oe_out,
   // SDRAM pins
   input wire logic [12:0] mem_addr_primary_out,
   input wire logic [3:0] mem_addr_inv_copy_b_out,
   input wire logic [3:0] mem_addr_inv_copy_c_out,
   input wire logic [1:0] mem_bank_select_out,
   input wire logic [63:0] mem_data_bus_out,
   input wire logic mem_data_bus_oe_out,
   input wire logic [7:0] mem_data_mask_out,
   input wire logic [5:0] mem_row_select_a_n_out,
   input wire logic [5:0] mem_row_select_b_n_out,
   input wire logic mem_row_strobe_n_out,
   input wire logic mem_col_strobe_n_out,
   input wire logic mem_write_enable_n_out,
   input wire logic [5:0] mem_row_clock_enable_out
);
   wire logic [2:0] cmd = {mem_row_strobe_n_out, mem_col_strobe_n_out, mem_write_enable_n_out};
   wire logic [5:0] sel = ~mem_row_select_a_n_out;
   wire logic act = (|sel) && cmd == sdp_pkg::CMD_ACT;
   wire logic take = req_valid_in && req_ready_out;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   property p_inv;
      mem_addr_inv_copy_b_out == ~mem_addr_primary_out[7:4] && mem_addr_inv_copy_c_out == ~mem_addr_primary_out[7:4];
   endproperty
   a_inv: assert property (p_inv) else $error("inverted copy wrong");
   property p_blank;
      mem_bank_select_out != $past(mem_bank_select_out) |-> &mem_row_select_a_n_out && &mem_row_select_b_n_out;
   endproperty
   a_blank: assert property (p_blank) else $error("select during bank change");
   property p_setup;
      act |-> $past(mem_bank_select_out, 1) == mem_bank_select_out && $past(mem_bank_select_out, 2) == mem_bank_select_out;
   endproperty
   a_setup: assert property (p_setup) else $error("bank setup short");
   property p_one_row;
      (|sel) && (cmd == sdp_pkg::CMD_ACT || cmd == sdp_pkg::CMD_RD || cmd == sdp_pkg::CMD_WR)
         |-> $onehot(sel) && mem_row_select_a_n_out == mem_row_select_b_n_out;
   endproperty
   a_one_row: assert property (p_one_row) else $error("row select not single");
   property p_act;
      take |-> ##3 act && mem_row_select_a_n_out == ~(6'h01 << $past(req_row_in, 3))
         && mem_addr_primary_out == $past(req_row_addr_in, 3) && mem_bank_select_out == $past(req_bank_in, 3);
   endproperty
   a_act: assert property (p_act) else $error("activate wrong");
   property p_col;
      take |-> ##4 (|sel) && !mem_col_strobe_n_out && mem_row_strobe_n_out
         && mem_write_enable_n_out == !$past(req_write_in, 4)
         && mem_addr_primary_out == ($past(req_col_addr_in, 4) | 13'h0400)
         && mem_data_mask_out == ($past(req_write_in, 4) ? ~$past(req_byte_en_in, 4) : 8'h00);
   endproperty
   a_col: assert property (p_col) else $error("column command wrong");
   property p_wdata;
      take && req_write_in |-> ##4 mem_data_bus_oe_out && mem_data_bus_out == $past(req_wdata_in, 4);
   endproperty
   a_wdata: assert property (p_wdata) else $error("write data wrong");
   property p_cke_act;
      act |-> (mem_row_clock_enable_out & sel) == sel && ($past(mem_row_clock_enable_out) & sel) == sel;
   endproperty
   a_cke_act: assert property (p_cke_act) else $error("row clock off at access");
   property p_strap;
      $rose(cpu_reset_n_in) |-> (cpu_address_bus_15_oe_out && cpu_address_bus_15_out == strap_in)[*2]
         ##[1:6] !cpu_address_bus_15_oe_out;
   endproperty
   a_strap: assert property (p_strap) else $error("strap drive wrong");
endmodule // sdp_pin_ctrl_properties
bind sdp_pin_ctrl sdp_pin_ctrl_properties u_props (.*);
`default_nettype wire

/* File: dv/sdp_sdram_model.sv */
// Behavioural SDRAM rows behind the controller pins
`timescale 1ns/10ps
`default_nettype none
module sdp_sdram_model (
   // Clock
   input wire logic clk_in,
   // Command and address
   input wire logic [5:0] row_sel_n_in,
   input wire logic [5:0] cke_in,
   input wire logic [2:0] cmd_in,
   input wire logic [1:0] bank_in,
   input wire logic [12:0] addr_in,
   // Data
   input wire logic [7:0] mask_in,
   input wire logic [63:0] dq_in,
   output logic [63:0] dq_out
);
   logic [63:0] mem [logic [30:0]];
   logic [12:0] open_row [0:31];
   logic [63:0] rd_q;
   logic [63:0] cur;
   logic rd_v = 1'b0;
   logic sel;
   logic [2:0] r;
   wire logic [30:0] key = {r, bank_in, open_row[{r, bank_in}], addr_in & 13'h1bff};
   // Row ignored while its clock enable is low
   always_comb begin
      sel = 1'b0;
      r = 3'h0;
      for (int i = 0; i < 6; i++) begin
         if (!row_sel_n_in[i] && cke_in[i]) begin
            sel = 1'b1;
            r = 3'(i);
         end
      end
   end
   initial dq_out = 64'h0;
   always @(posedge clk_in) begin
      rd_v <= 1'b0;
      if (sel && cmd_in == sdp_pkg::CMD_ACT) open_row[{r, bank_in}] <= addr_in;
      if (sel && cmd_in == sdp_pkg::CMD_WR) begin
         cur = mem.exists(key) ? mem[key] : 64'h0;
         for (int b = 0; b < 8; b++) if (!mask_in[b]) cur[b*8 +: 8] = dq_in[b*8 +: 8];
         mem[key] = cur;
      end
      if (sel && cmd_in == sdp_pkg::CMD_RD && mask_in == 8'h00) begin
         rd_v <= 1'b1;
         rd_q <= mem.exists(key) ? mem[key] : 64'h0;
      end
      // Latency two; released bus toggles
      dq_out <= rd_v ? rd_q : ~dq_out;
   end
endmodule // sdp_sdram_model
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the SDRAM pin controller
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic req_valid_in = 1'b0;
   logic req_write_in = 1'b0;
   logic [2:0] req_row_in = 3'h0;
   logic [1:0] req_bank_in = 2'h0;
   logic [12:0] req_row_addr_in = 13'h0000;
   logic [12:0] req_col_addr_in = 13'h0000;
   logic [63:0] req_wdata_in = 64'h0;
   logic [7:0] req_byte_en_in = 8'h00;
   logic refresh_req_in = 1'b0;
   logic suspend_in = 1'b0;
   logic rd_ready_in = 1'b0;
   logic cpu_reset_n_in = 1'b0;
   logic strap_in = 1'b1;
   logic req_ready_out, refresh_ack_out, suspended_out, rd_valid_out, mem_data_bus_oe_out;
   logic cpu_address_bus_15_out, cpu_address_bus_15_oe_out;
   logic mem_row_strobe_n_out, mem_col_strobe_n_out, mem_write_enable_n_out;
   logic [63:0] rd_data_out, mem_data_bus_out, model_dq;
   logic [12:0] mem_addr_primary_out;
   logic [3:0] mem_addr_inv_copy_b_out, mem_addr_inv_copy_c_out;
   logic [1:0] mem_bank_select_out;
   logic [7:0] mem_data_mask_out;
   logic [5:0] mem_row_select_a_n_out, mem_row_select_b_n_out, mem_row_clock_enable_out;
   wire logic [63:0] mem_data_bus_in = mem_data_bus_oe_out ? mem_data_bus_out : model_dq;
   wire logic [2:0] cmd = {mem_row_strobe_n_out, mem_col_strobe_n_out, mem_write_enable_n_out};
   int err_count = 0;
   int checks = 0;
   int cycles = 0;
   sdp_pin_ctrl dut (.*);
   sdp_sdram_model u_mem (
      .clk_in(clk_in),
      .row_sel_n_in(mem_row_select_a_n_out),
      .cke_in(mem_row_clock_enable_out),
      .cmd_in(cmd),
      .bank_in(mem_bank_select_out),
      .addr_in(mem_addr_primary_out),
      .mask_in(mem_data_mask_out),
      .dq_in(mem_data_bus_in),
      .dq_out(model_dq)
   );
   always #12.5 clk_in = ~clk_in;
   function automatic logic [63:0] pat(input int i);
      return 64'h0123_4567_89ab_cdef ^ {8{8'(i * 17)}};
   endfunction
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         summarize();
      end
   end
   // One access; location i sets row, bank and addresses
   task automatic acc(input logic w, input int i, input logic [63:0] d, input logic [7:0] be, output logic ok);
      int n;
      @(posedge clk_in);
      #1 req_write_in = w;
      req_row_in = 3'(i % 6);
      req_bank_in = 2'(i % 4);
      req_row_addr_in = 13'h1fff - 13'(i);
      req_col_addr_in = 13'(i * 65);
      req_wdata_in = d;
      req_byte_en_in = be;
      req_valid_in = 1'b1;
      @(negedge clk_in);
      for (n = 0; n < 40 && req_ready_out !== 1'b1; n++) @(negedge clk_in);
      ok = req_ready_out;
      @(posedge clk_in);
      #1 req_valid_in = 1'b0;
   endtask
   task automatic pop(input logic [63:0] exp);
      int n;
      @(posedge clk_in);
      #1 rd_ready_in = 1'b1;
      @(negedge clk_in);
      for (n = 0; n < 40 && rd_valid_out !== 1'b1; n++) @(negedge clk_in);
      check("read data", rd_data_out, exp);
      @(posedge clk_in);
      #1 rd_ready_in = 1'b0;
   endtask
   task automatic t_strap(input logic s);
      @(posedge clk_in);
      #1 strap_in = s;
      cpu_reset_n_in = 1'b0;
      repeat (6) @(posedge clk_in);
      #1 cpu_reset_n_in = 1'b1;
      repeat (2) @(posedge clk_in);
      #1 check("strap drive", {cpu_address_bus_15_oe_out, cpu_address_bus_15_out}, {1'b1, s});
      repeat (8) @(posedge clk_in);
      #1 check("strap release", cpu_address_bus_15_oe_out, 1'b0);
      $display("test strap %0d done", s);
   endtask
   // Rows and banks, fifo filled while reader stalls
   task automatic t_fill();
      logic ok;
      for (int i = 0; i < 8; i++) acc(1'b1, i, pat(i), 8'hff, ok);
      for (int i = 0; i < 8; i++) acc(1'b0, i, 64'h0, 8'h00, ok);
      acc(1'b0, 0, 64'h0, 8'h00, ok);
      check("read taken when full", ok, 1'b0);
      for (int i = 0; i < 8; i++) pop(pat(i));
      check("valid after drain", rd_valid_out, 1'b0);
      $display("test fill done");
   endtask
   task automatic t_mask();
      logic ok;
      acc(1'b1, 3, 64'h0, 8'h5a, ok);
      acc(1'b0, 3, 64'h0, 8'h00, ok);
      pop(pat(3) & 64'hff00_ff00_00ff_00ff);
      $display("test mask done");
   endtask
   task automatic t_refresh();
      int n;
      @(posedge clk_in);
      #1 refresh_req_in = 1'b1;
      @(negedge clk_in);
      for (n = 0; n < 40 && refresh_ack_out !== 1'b1; n++) @(negedge clk_in);
      check("refresh rows", {mem_row_select_a_n_out, mem_row_clock_enable_out}, 12'h03f);
      check("refresh command", cmd, sdp_pkg::CMD_REF);
      @(posedge clk_in);
      #1 refresh_req_in = 1'b0;
      repeat (8) @(posedge clk_in);
      #1 check("idle clock enables", mem_row_clock_enable_out, sdp_pkg::ROWS_NONE);
      $display("test refresh done");
   endtask
   task automatic t_suspend();
      int n;
      logic ok;
      @(posedge clk_in);
      #1 suspend_in = 1'b1;
      @(negedge clk_in);
      for (n = 0; n < 40 && suspended_out !== 1'b1; n++) @(negedge clk_in);
      check("self refresh enables", mem_row_clock_enable_out, sdp_pkg::ROWS_NONE);
      check("self refresh command", cmd, sdp_pkg::CMD_REF);
      @(posedge clk_in);
      #1 suspend_in = 1'b0;
      @(negedge clk_in);
      for (n = 0; n < 40 && suspended_out !== 1'b0; n++) @(negedge clk_in);
      acc(1'b1, 5, ~pat(5), 8'hff, ok);
      acc(1'b0, 5, 64'h0, 8'h00, ok);
      pop(~pat(5));
      $display("test suspend done");
   endtask
   initial begin
      repeat (10) @(posedge clk_in);
      #1 arst_n_in = 1'b1;
      t_strap(1'b1);
      t_strap(1'b0);
      t_strap(1'b1);
      t_fill();
      t_mask();
      t_refresh();
      t_suspend();
      summarize();
   end
endmodule // tb
`default_nettype wire
